//--- hw/erm_pkg.sv
// Package: constants of the recovery page block
package erm_pkg;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] ERM_OFF_SEL_A   = 8'h00;
   localparam logic [7:0] ERM_OFF_SEL_B   = 8'h04;
   localparam logic [7:0] ERM_OFF_CMD     = 8'h08;
   localparam logic [7:0] ERM_OFF_STATUS  = 8'h0C;
   localparam logic [7:0] ERM_OFF_REC0    = 8'h20;
   localparam logic [7:0] ERM_OFF_REC1    = 8'h24;
   localparam logic [7:0] ERM_OFF_REC2    = 8'h28;
   localparam logic [7:0] ERM_OFF_FLEX    = 8'h40;
   localparam int         ERM_FLEX_WORDS  = 8;
   localparam int         ERM_FLEX_IDX_W  = 3;

   // ****************************************
   // Command register bits
   // ****************************************
   localparam int ERM_CMD_PF       = 0;
   localparam int ERM_CMD_SAVE     = 1;
   localparam int ERM_CMD_DEFAULTS = 2;
   localparam int ERM_CMD_RESTORE  = 3;

   // ****************************************
   // Recovery page layout and defaults
   // ****************************************
   localparam logic [7:0] ERM_REC_CODE      = 8'h01;
   localparam logic [7:0] ERM_REC_LEN       = 8'h0A;
   localparam logic [7:0] ERM_PAGE_CODE_MSK = 8'h3F;
   localparam logic [7:0] ERM_PS_BIT        = 8'h80;
   localparam int         ERM_FLG_REALLOC   = 7;
   localparam int         ERM_FLG_CONT      = 4;
   localparam int         ERM_FLG_POST      = 2;
   localparam int         ERM_FLG_NOCORR    = 0;
   localparam logic [7:0] ERM_FLG_CHG_MSK   = 8'h95;
   localparam logic [7:0] ERM_FLG_DEF       = 8'h80;
   localparam logic [7:0] ERM_RRC_DEF       = 8'h1F;
   localparam logic [7:0] ERM_RRC_MIN_BAD   = 8'h03;
   localparam logic [7:0] ERM_RRC_SUBST     = 8'h04;
   localparam logic [7:0] ERM_WRC_DEF       = 8'h03;

   // ****************************************
   // Flexible disk page contents
   // ****************************************
   localparam logic [7:0]  ERM_FLEX_CODE    = 8'h05;
   localparam logic [7:0]  ERM_FLEX_LEN     = 8'h1E;
   localparam logic [15:0] ERM_XFER_RATE    = 16'h3E80;
   localparam logic [7:0]  ERM_HEADS        = 8'h40;
   localparam logic [7:0]  ERM_SECTORS      = 8'h20;
   localparam logic [15:0] ERM_BLK_SMALL    = 16'h0200;
   localparam logic [15:0] ERM_BLK_LARGE    = 16'h0800;
   localparam logic [7:0]  ERM_MOTOR_NEVER  = 8'hFF;
   localparam logic [15:0] ERM_ROT_RATE_DEF = 16'h1194;
   localparam logic [15:0] ERM_CYL_DEF      = 16'h0100;

   // ****************************************
   // Error thresholds and sense keys
   // ****************************************
   localparam logic [3:0] ERM_ECC_RECOV_LO = 4'h7;
   localparam logic [3:0] ERM_ECC_RECOV_HI = 4'h8;
   localparam logic [2:0] ERM_FMT_ONE_FAIL = 3'h1;
   localparam logic [2:0] ERM_FMT_MAX_FAIL = 3'h4;
   localparam logic [3:0] ERM_SK_NONE      = 4'h0;
   localparam logic [3:0] ERM_SK_RECOVERED = 4'h1;
   localparam logic [3:0] ERM_SK_MEDIUM    = 4'h3;
   localparam logic [3:0] ERM_SK_ILLEGAL   = 4'h5;
   localparam int         ERM_ST_SENSE_LSB = 4;

endpackage : erm_pkg

//--- hw/erm_recovery_pages.sv
// Error recovery and flexible disk mode pages with Wishbone register access
// Functional notes
// R1 - Recovery page 01h, length 0Ah, four flags
// R2 - Reallocation flag governs alternate block assignment
// R3 - Continuous read delivers bad data, good status
// R4 - Post flag turns recovery into check condition
// R5 - Seven or eight ECC bytes means recovered
// R6 - Replaced defective write sector means recovered
// R7 - One failed copy recovered, more medium error
// R8 - Correction disable flag skips correcting reads
// R9 - Read retry three or less becomes four
// R10 - Write retry not three becomes three
// R11 - Only flags and retry bytes are changeable
// R12 - Defaults: realloc set, 1Fh, 03h
// R13 - Recovery page can be saved persistently; the saved copy here is reset to defaults by rst_i
// R14 - Host keeps recovery page at defaults
// R15 - Flexible page 05h, 1Eh, not changeable
// R16 - Motor off delay FFh, never stop
// R17 - Bytes per sector is 200h or 800h
// R18 - Rate in kbit/s, rotation in rpm
// R19 - Logical geometry, 40h heads, 20h sectors
// R20 - Host drivers should avoid flexible page
// R21 - Page format bit zero gives check condition
// R22 - Reserved bytes read zero, writes ignored
`timescale 1ns/10ps
module erm_recovery_pages
   import erm_pkg::*;
#(
   parameter logic [15:0] ROT_RATE  = ERM_ROT_RATE_DEF,
   parameter logic [15:0] CYLINDERS = ERM_CYL_DEF
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        blk_large_i,
   input  wire logic        rd_done_i,
   input  wire logic        rd_uncorr_i,
   input  wire logic        rd_corr_i,
   input  wire logic [3:0]  rd_ecc_bytes_i,
   input  wire logic        wr_done_i,
   input  wire logic        wr_defect_i,
   input  wire logic        fmt_done_i,
   input  wire logic [2:0]  fmt_fail_cnt_i,
   output logic             cmp_valid_o,
   output logic             cmp_check_o,
   output logic      [3:0]  cmp_sense_o,
   output logic             alloc_alt_o,
   output logic             deliver_bad_o,
   output logic             apply_corr_o,
   output logic             write_realloc_o,
   output logic             continuous_read_o,
   output logic             post_error_o,
   output logic             correction_disable_o,
   output logic      [7:0]  read_retry_o,
   output logic      [7:0]  write_retry_o,
   output logic             save_req_o
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] byte_mask(input logic [3:0] sel);
      byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : byte_mask

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
      merge = (old_v & ~byte_mask(sel)) | (new_v & byte_mask(sel));
   endfunction : merge

   // ****************************************
   // State
   // ****************************************
   logic [7:0]  flags_reg,  flags_next;
   logic [7:0]  rrc_reg,    rrc_next;
   logic [7:0]  wrc_reg,    wrc_next;
   logic [7:0]  sv_flags_reg;
   logic [7:0]  sv_rrc_reg;
   logic [7:0]  sv_wrc_reg;
   logic [31:0] sel_a_reg;
   logic [7:0]  sel_b_reg;
   logic        st_check_reg, st_check_next;
   logic [3:0]  st_sense_reg, st_sense_next;
   logic        save_reg;
   logic        ack_reg;
   logic [31:0] dat_reg,  dat_next;
   logic        blk_meta_reg;
   logic        blk_sync_reg;
   logic        cmp_valid_reg, cmp_check_reg;
   logic [3:0]  cmp_sense_reg;
   logic        alloc_reg, deliver_reg, corr_reg;

   // ****************************************
   // Bus decode
   // ****************************************
   wire        req     = cyc_i & stb_i & ~ack_reg;
   wire        wr_req  = req & we_i;
   wire        hit_a   = adr_i == ERM_OFF_SEL_A;
   wire        hit_b   = adr_i == ERM_OFF_SEL_B;
   wire        hit_cmd = adr_i == ERM_OFF_CMD;
   wire        hit_st  = adr_i == ERM_OFF_STATUS;
   wire        hit_r0  = adr_i == ERM_OFF_REC0;
   wire        hit_r1  = adr_i == ERM_OFF_REC1;
   wire        hit_r2  = adr_i == ERM_OFF_REC2;
   wire        hit_fx  = adr_i[7:5] == ERM_OFF_FLEX[7:5] && adr_i[1:0] == 2'b00;
   wire [ERM_FLEX_IDX_W-1:0] fx_idx = adr_i[ERM_FLEX_IDX_W+1:2];
   wire        cmd_go  = wr_req & hit_cmd & sel_i[0];
   wire [31:0] sel_a_merged = merge(sel_a_reg, dat_i, sel_i);
   wire [31:0] sel_b_merged = merge({24'h0, sel_b_reg}, dat_i, sel_i);

   // ****************************************
   // Mode select evaluation
   // ****************************************
   wire [7:0] ms_code  = sel_a_reg[7:0] & ERM_PAGE_CODE_MSK;
   wire [7:0] ms_len   = sel_a_reg[15:8];
   wire [7:0] ms_flags = sel_a_reg[23:16] & ERM_FLG_CHG_MSK;   // R11 R22
   wire [7:0] ms_rrc   = sel_a_reg[31:24];
   wire [7:0] ms_wrc   = sel_b_reg;
   wire       pf_ok    = dat_i[ERM_CMD_PF];
   wire       is_rec   = ms_code == ERM_REC_CODE && ms_len == ERM_REC_LEN;     // R1
   wire       is_flex  = ms_code == ERM_FLEX_CODE && ms_len == ERM_FLEX_LEN;   // R15
   wire       rrc_low  = ms_rrc <= ERM_RRC_MIN_BAD;                            // R9
   wire       wrc_bad  = ms_wrc != ERM_WRC_DEF;                                // R10

   always_comb begin
      flags_next    = flags_reg;
      rrc_next      = rrc_reg;
      wrc_next      = wrc_reg;
      st_check_next = st_check_reg;
      st_sense_next = st_sense_reg;
      if (cmd_go) begin
         st_check_next = 1'b0;
         st_sense_next = ERM_SK_NONE;
         if (dat_i[ERM_CMD_DEFAULTS]) begin
            flags_next = ERM_FLG_DEF;   // R12
            rrc_next   = ERM_RRC_DEF;   // R12
            wrc_next   = ERM_WRC_DEF;   // R12
         end else if (dat_i[ERM_CMD_RESTORE]) begin
            flags_next = sv_flags_reg;  // R13
            rrc_next   = sv_rrc_reg;    // R13
            wrc_next   = sv_wrc_reg;    // R13
         end else if (!pf_ok) begin
            st_check_next = 1'b1;       // R21
            st_sense_next = ERM_SK_ILLEGAL;
         end else if (is_rec) begin
            flags_next = ms_flags;                              // R11
            rrc_next   = rrc_low ? ERM_RRC_SUBST : ms_rrc;      // R9
            wrc_next   = ERM_WRC_DEF;                           // R10
            if (rrc_low || wrc_bad) begin
               st_check_next = 1'b1;                            // R9 R10
               st_sense_next = ERM_SK_RECOVERED;
            end
         end else if (!is_flex) begin
            st_check_next = 1'b1;
            st_sense_next = ERM_SK_ILLEGAL;
         end
         // Flexible page writes change nothing
      end
   end

   // ****************************************
   // Page images
   // ****************************************
   wire [15:0] blk_len = blk_sync_reg ? ERM_BLK_LARGE : ERM_BLK_SMALL;   // R17
   wire [31:0] rec_w0  = {rrc_reg, flags_reg, ERM_REC_LEN, ERM_PS_BIT | ERM_REC_CODE}; // R1 R13
   wire [31:0] rec_w2  = {24'h0, wrc_reg};                                 // R22
   wire [31:0] flex_img [ERM_FLEX_WORDS];

   // Multi-byte fields go MSB first
   assign flex_img[0] = {ERM_XFER_RATE[7:0], ERM_XFER_RATE[15:8],
                         ERM_FLEX_LEN, ERM_FLEX_CODE};                     // R15 R18
   assign flex_img[1] = {blk_len[7:0], blk_len[15:8], ERM_SECTORS, ERM_HEADS}; // R17 R19
   assign flex_img[2] = {16'h0, CYLINDERS[7:0], CYLINDERS[15:8]};          // R19
   assign flex_img[3] = 32'h0;
   assign flex_img[4] = 32'h0;
   assign flex_img[5] = {24'h0, ERM_MOTOR_NEVER};                          // R16
   assign flex_img[6] = 32'h0;
   assign flex_img[7] = {16'h0, ROT_RATE[7:0], ROT_RATE[15:8]};            // R18 R19

   wire [31:0] status_w = {20'h0, 4'h0, st_sense_reg, 3'h0, st_check_reg};

   always_comb begin
      dat_next = 32'h0;
      if (hit_a)       dat_next = sel_a_reg;
      else if (hit_b)  dat_next = {24'h0, sel_b_reg};
      else if (hit_st) dat_next = status_w;
      else if (hit_r0) dat_next = rec_w0;
      else if (hit_r1) dat_next = 32'h0;                                   // R22
      else if (hit_r2) dat_next = rec_w2;
      else if (hit_fx) dat_next = flex_img[fx_idx];
   end

   // ****************************************
   // Media event completion
   // ****************************************
   wire ecc_recov = rd_ecc_bytes_i >= ERM_ECC_RECOV_LO
                    && rd_ecc_bytes_i <= ERM_ECC_RECOV_HI;                 // R5
   wire fmt_one   = fmt_fail_cnt_i == ERM_FMT_ONE_FAIL;                    // R7
   wire fmt_many  = fmt_fail_cnt_i > ERM_FMT_ONE_FAIL
                    && fmt_fail_cnt_i <= ERM_FMT_MAX_FAIL;                 // R7
   wire per       = flags_reg[ERM_FLG_POST];
   wire realloc   = flags_reg[ERM_FLG_REALLOC];
   wire cont      = flags_reg[ERM_FLG_CONT];
   wire nocorr    = flags_reg[ERM_FLG_NOCORR];

   logic       ev_valid, ev_check, ev_alloc, ev_deliver, ev_corr;
   logic [3:0] ev_sense;

   // Only one completion is reported per cycle; format wins, then write, then read
   always_comb begin
      ev_valid   = 1'b0;
      ev_check   = 1'b0;
      ev_sense   = ERM_SK_NONE;
      ev_alloc   = 1'b0;
      ev_deliver = 1'b0;
      ev_corr    = 1'b0;
      if (fmt_done_i) begin
         ev_valid = 1'b1;
         if (fmt_many) begin
            ev_check = 1'b1;                                               // R7
            ev_sense = ERM_SK_MEDIUM;
         end else if (fmt_one && per) begin
            ev_check = 1'b1;                                               // R7 R4
            ev_sense = ERM_SK_RECOVERED;
         end
      end else if (wr_done_i) begin
         ev_valid = 1'b1;
         if (wr_defect_i && realloc) begin
            ev_alloc = 1'b1;                                               // R2
            if (per) begin
               ev_check = 1'b1;                                            // R6 R4
               ev_sense = ERM_SK_RECOVERED;
            end
         end else if (wr_defect_i) begin
            // Without reallocation the defect cannot be hidden
            ev_check = 1'b1;                                               // R2
            ev_sense = ERM_SK_MEDIUM;
         end
      end else if (rd_done_i) begin
         ev_valid = 1'b1;
         if (rd_uncorr_i) begin
            ev_deliver = cont;                                             // R3
            ev_check   = ~cont;                                            // R3
            ev_sense   = cont ? ERM_SK_NONE : ERM_SK_MEDIUM;
         end else if (rd_corr_i && !nocorr) begin
            ev_corr = 1'b1;                                                // R8
            if (ecc_recov && per) begin
               ev_check = 1'b1;                                            // R5 R4
               ev_sense = ERM_SK_RECOVERED;
            end
         end
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_reg    <= ERM_FLG_DEF;   // R12
         rrc_reg      <= ERM_RRC_DEF;   // R12
         wrc_reg      <= ERM_WRC_DEF;   // R12
         st_check_reg <= 1'b0;
         st_sense_reg <= ERM_SK_NONE;
      end else begin
         flags_reg    <= flags_next;
         rrc_reg      <= rrc_next;
         wrc_reg      <= wrc_next;
         st_check_reg <= st_check_next;
         st_sense_reg <= st_sense_next;
      end
   end

   // Saved copy is lost on reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sv_flags_reg <= ERM_FLG_DEF;
         sv_rrc_reg   <= ERM_RRC_DEF;
         sv_wrc_reg   <= ERM_WRC_DEF;
         save_reg     <= 1'b0;
      end else begin
         save_reg <= cmd_go & dat_i[ERM_CMD_SAVE] & ~st_check_next;        // R13
         if (cmd_go && dat_i[ERM_CMD_SAVE] && !st_check_next) begin
            sv_flags_reg <= flags_next;                                    // R13
            sv_rrc_reg   <= rrc_next;
            sv_wrc_reg   <= wrc_next;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_a_reg <= 32'h0;
         sel_b_reg <= 8'h0;
         ack_reg   <= 1'b0;
         dat_reg   <= 32'h0;
      end else begin
         ack_reg <= req;
         if (req && !we_i) begin
            dat_reg <= dat_next;
         end
         if (wr_req && hit_a) begin
            sel_a_reg <= sel_a_merged;
         end
         if (wr_req && hit_b) begin
            sel_b_reg <= sel_b_merged[7:0];
         end
      end
   end

   // Strap comes from outside, so it is synchronised
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         blk_meta_reg <= 1'b0;
         blk_sync_reg <= 1'b0;
      end else begin
         blk_meta_reg <= blk_large_i;
         blk_sync_reg <= blk_meta_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_valid_reg <= 1'b0;
         cmp_check_reg <= 1'b0;
         cmp_sense_reg <= ERM_SK_NONE;
         alloc_reg     <= 1'b0;
         deliver_reg   <= 1'b0;
         corr_reg      <= 1'b0;
      end else begin
         cmp_valid_reg <= ev_valid;
         cmp_check_reg <= ev_check;
         cmp_sense_reg <= ev_sense;
         alloc_reg     <= ev_alloc;
         deliver_reg   <= ev_deliver;
         corr_reg      <= ev_corr;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign dat_o                = dat_reg;
   assign ack_o                = ack_reg;
   assign cmp_valid_o          = cmp_valid_reg;
   assign cmp_check_o          = cmp_check_reg;
   assign cmp_sense_o          = cmp_sense_reg;
   assign alloc_alt_o          = alloc_reg;
   assign deliver_bad_o        = deliver_reg;
   assign apply_corr_o         = corr_reg;
   assign write_realloc_o      = flags_reg[ERM_FLG_REALLOC];
   assign continuous_read_o    = flags_reg[ERM_FLG_CONT];
   assign post_error_o         = flags_reg[ERM_FLG_POST];
   assign correction_disable_o = flags_reg[ERM_FLG_NOCORR];
   assign read_retry_o         = rrc_reg;
   assign write_retry_o        = wrc_reg;
   assign save_req_o           = save_reg;

endmodule : erm_recovery_pages

//--- verif/erm_recovery_pages_chk.sv
// Checker: properties on the recovery page ports
`timescale 1ns/10ps
module erm_recovery_pages_chk
   import erm_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       cyc_i,
   input wire logic       stb_i,
   input wire logic       ack_o,
   input wire logic       rd_done_i,
   input wire logic       rd_uncorr_i,
   input wire logic       rd_corr_i,
   input wire logic [3:0] rd_ecc_bytes_i,
   input wire logic       wr_done_i,
   input wire logic       wr_defect_i,
   input wire logic       fmt_done_i,
   input wire logic [2:0] fmt_fail_cnt_i,
   input wire logic       cmp_valid_o,
   input wire logic       cmp_check_o,
   input wire logic [3:0] cmp_sense_o,
   input wire logic       alloc_alt_o,
   input wire logic       deliver_bad_o,
   input wire logic       apply_corr_o,
   input wire logic       write_realloc_o,
   input wire logic       continuous_read_o,
   input wire logic       post_error_o,
   input wire logic       correction_disable_o,
   input wire logic [7:0] read_retry_o,
   input wire logic [7:0] write_retry_o
);
   // ****************************************
   // Properties
   // ****************************************
   // Lower priority events count only when no higher priority event comes with them
   wire logic rd_only = rd_done_i & ~wr_done_i & ~fmt_done_i;
   wire logic wr_only = wr_done_i & ~fmt_done_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack width");
   property p_cont; rd_only && rd_uncorr_i && continuous_read_o
      |=> cmp_valid_o && deliver_bad_o && !cmp_check_o; endproperty
   a_cont: assert property (p_cont) else $error("cont read");
   property p_nocont; rd_only && rd_uncorr_i && !continuous_read_o
      |=> cmp_check_o && cmp_sense_o == 4'h3 && !deliver_bad_o; endproperty
   a_nocont: assert property (p_nocont) else $error("uncorr read");
   property p_realloc; wr_only && wr_defect_i |=> alloc_alt_o == $past(write_realloc_o);
   endproperty
   a_realloc: assert property (p_realloc) else $error("realloc");
   property p_corr; rd_only && rd_corr_i && !rd_uncorr_i
      |=> apply_corr_o != $past(correction_disable_o); endproperty
   a_corr: assert property (p_corr) else $error("correction");
   property p_ecc; rd_only && rd_corr_i && !rd_uncorr_i && !correction_disable_o &&
      post_error_o && rd_ecc_bytes_i inside {4'h7, 4'h8}
      |=> cmp_check_o && cmp_sense_o == 4'h1; endproperty
   a_ecc: assert property (p_ecc) else $error("ecc recovery");
   property p_post; wr_only && wr_defect_i && write_realloc_o
      |=> cmp_check_o == $past(post_error_o); endproperty
   a_post: assert property (p_post) else $error("write posting");
   property p_fmt; fmt_done_i && fmt_fail_cnt_i inside {3'h2, 3'h3, 3'h4}
      |=> cmp_check_o && cmp_sense_o == 4'h3; endproperty
   a_fmt: assert property (p_fmt) else $error("format error");
   property p_retry; read_retry_o > 8'h03 && write_retry_o == 8'h03; endproperty
   a_retry: assert property (p_retry) else $error("retry range");
endmodule : erm_recovery_pages_chk

bind erm_recovery_pages erm_recovery_pages_chk chk_u (.*);

//--- verif/erm_host_model.sv
// Host model: Wishbone master for mode commands
`timescale 1ns/10ps
module erm_host_model
   import erm_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] rd_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic      [7:0]  adr_o,
   output logic      [3:0]  sel_o,
   output logic      [31:0] dat_o
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'hF;
      dat_o = 32'h0;
   end
   // Request held until ack; the bench watchdog ends a dead wait
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= d;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = rd_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
   endtask : wb
   task automatic mode_sel(input logic [31:0] aw, input logic [7:0] wrc,
                           input logic [3:0] cmd);
      logic [31:0] q;
      wb(1'b1, ERM_OFF_SEL_A, aw, q);
      wb(1'b1, ERM_OFF_SEL_B, {24'h0, wrc}, q);
      wb(1'b1, ERM_OFF_CMD, {28'h0, cmd}, q);
   endtask : mode_sel
endmodule : erm_host_model

//--- verif/testbench.sv
// Testbench: mode selects and media events against a model
`timescale 1ns/10ps
module testbench
   import erm_pkg::*;
;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i, stb_i, we_i, ack_o, blk_large_i = 1'b0;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o;
   logic rd_done_i = 1'b0, rd_uncorr_i = 1'b0, rd_corr_i = 1'b0, wr_done_i = 1'b0;
   logic wr_defect_i = 1'b0, fmt_done_i = 1'b0;
   logic [3:0] rd_ecc_bytes_i = 4'h0;
   logic [2:0] fmt_fail_cnt_i = 3'h0;
   logic cmp_valid_o, cmp_check_o, alloc_alt_o, deliver_bad_o, apply_corr_o, save_req_o;
   logic write_realloc_o, continuous_read_o, post_error_o, correction_disable_o;
   logic [3:0] cmp_sense_o;
   logic [7:0] read_retry_o, write_retry_o;
   int failures = 0, n_tests = 0, m_flg, m_rrc, s_flg, s_rrc, m_save = 0, n_save = 0;
   logic [31:0] q;
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) if (save_req_o === 1'b1) n_save++;
   erm_host_model host_u (.clk_i(clk_i), .ack_i(ack_o), .rd_i(dat_o), .cyc_o(cyc_i),
      .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
   erm_recovery_pages dut_u (.*);
   // ****************************************
   // Checking tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      host_u.wb(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask : rd_chk
   task print_verdict;
      if (failures == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict
   function automatic logic [31:0] fx(input int i, input logic b);
      case (i)
         0: fx = 32'h803E1E05;
         1: fx = b ? 32'h00082040 : 32'h00022040;
         2: fx = 32'h00000001;
         5: fx = 32'h000000FF;
         7: fx = 32'h00009411;
         default: fx = 32'h0;
      endcase
   endfunction : fx
   task automatic sel_page(input logic [31:0] aw, input logic [7:0] wrc, input logic [3:0] cmd);
      int r, st;
      r = aw[31:24];
      st = -1;
      if (cmd[2]) begin
         m_flg = 8'h80;
         m_rrc = 8'h1F;
      end else if (cmd[3]) begin
         m_flg = s_flg;
         m_rrc = s_rrc;
      end else if (!cmd[0]) st = 8'h51;
      else if (aw[5:0] == 6'h01 && aw[15:8] == 8'h0A) begin
         m_flg = aw[23:16] & 8'h95;
         m_rrc = (r <= 3) ? 4 : r;
         st = (r <= 3 || wrc != 8'h03) ? 8'h11 : 8'h00;
         if (cmd[1] && st == 0) begin
            s_flg = m_flg;
            s_rrc = m_rrc;
            m_save++;
         end
      end else if (aw[5:0] == 6'h05 && aw[15:8] == 8'h1E) st = 8'h00;
      else st = 8'h51;
      host_u.mode_sel(aw, wrc, cmd);
      if (st >= 0) rd_chk(ERM_OFF_STATUS, st);
      rd_chk(ERM_OFF_REC0, {m_rrc[7:0], m_flg[7:0], 16'h0A81});
      rd_chk(ERM_OFF_REC2, 32'h00000003);
      chk({write_realloc_o, continuous_read_o, post_error_o, correction_disable_o},
          {m_flg[7], m_flg[4], m_flg[2], m_flg[0]});
   endtask : sel_page
   task automatic ev();
      logic [31:0] r;
      logic [3:0] e;
      int c = 0, s = 0, v, al = 0, bd = 0, co = 0;
      r = $urandom;
      e = 4'h5 + r[7:5];
      v = (r[2:0] != 0);
      @(posedge clk_i);
      rd_done_i <= r[0];
      wr_done_i <= r[1];
      fmt_done_i <= r[2];
      rd_uncorr_i <= r[3];
      rd_corr_i <= !r[3] && r[4];
      rd_ecc_bytes_i <= e;
      wr_defect_i <= r[9];
      fmt_fail_cnt_i <= r[12:10];
      if (r[2]) begin
         if (r[12:10] == 1) begin c = m_flg[2]; s = m_flg[2]; end
         else if (r[12:10] >= 2 && r[12:10] <= 4) begin c = 1; s = 3; end
      end else if (r[1]) begin
         if (r[9] && m_flg[7]) begin al = 1; c = m_flg[2]; s = m_flg[2]; end
         else if (r[9]) begin c = 1; s = 3; end
      end else if (r[0]) begin
         if (r[3] && m_flg[4]) bd = 1;
         else if (r[3]) begin c = 1; s = 3; end
         else if (r[4] && !m_flg[0]) begin
            co = 1;
            if ((e == 7 || e == 8) && m_flg[2]) begin c = 1; s = 1; end
         end
      end
      @(posedge clk_i);
      rd_done_i <= 1'b0;
      wr_done_i <= 1'b0;
      fmt_done_i <= 1'b0;
      @(negedge clk_i);
      chk({cmp_valid_o, alloc_alt_o, deliver_bad_o, apply_corr_o}, {v[0], al[0], bd[0], co[0]});
      if (v) chk({cmp_check_o, cmp_sense_o}, {c[0], s[3:0]});
   endtask : ev
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      print_verdict();
   end
   initial begin
      q = $urandom(21165);
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      m_flg = 8'h80; m_rrc = 8'h1F; s_flg = 8'h80; s_rrc = 8'h1F;
      rd_chk(ERM_OFF_REC0, 32'h1F800A81);
      rd_chk(ERM_OFF_REC1, 32'h0);
      rd_chk(8'hFC, 32'h0);
      chk({read_retry_o, write_retry_o}, 16'h1F03);
      for (int b = 0; b < 2; b++) begin
         blk_large_i <= b[0];
         repeat (4) @(posedge clk_i);
         for (int i = 0; i < 8; i++) rd_chk(ERM_OFF_FLEX + 8'(4 * i), fx(i, b[0]));
      end
      for (int i = 0; i < 5; i++) sel_page({i == 3 ? 8'h00 : 8'(i), 8'($urandom), 16'h0A81},
         8'(i), 4'h1);
      sel_page({8'h20, 8'hFF, 16'h0A01}, 8'h03, 4'h0);
      sel_page({8'h20, 8'hFF, 16'h0A02}, 8'h03, 4'h1);
      sel_page({8'h20, 8'hFF, 16'h0B01}, 8'h03, 4'h1);
      sel_page({8'h20, 8'hFF, 16'h1E05}, 8'h03, 4'h1);
      rd_chk(ERM_OFF_FLEX, fx(0, 1'b1));
      sel_page({8'h27, 8'h95, 16'h0A01}, 8'h03, 4'h3);
      sel_page(32'h0, 8'h03, 4'h4);
      sel_page(32'h0, 8'h03, 4'h8);
      chk(n_save, m_save);
      for (int f = 0; f < 16; f++) begin
         sel_page({8'h10, 8'($urandom) & 8'h6A | {f[3], 2'b00, f[2], 1'b0, f[1], 1'b0, f[0]},
            16'h0A01}, 8'h03, 4'h1);
         repeat (60) ev();
      end
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      m_flg = 8'h80; m_rrc = 8'h1F;
      rd_chk(ERM_OFF_REC0, 32'h1F800A81);
      print_verdict();
   end
endmodule : testbench
